// file: src/wsg_pkg.sv
// Summary of operation
// R1: 1-16 waits non-pipelined, 0-15 pipelined
// R2: Waits for both CPU and DMA cycles
// R3: As master, sample ready input for end
// R4: As slave, track pipelining from ready/strobe
// R5: Drive active-low ready output
// R6: Own registers: 2-5 waits, 7 back-to-back
// R7: Pipelined own-register cycle gets one wait minimum
// R8: Interrupt acknowledge gets exactly five waits
// R9: Refresh uses refresh count; select 11 disables
// R10: Select 00/01/10 picks register 0/1/2
// R11: Upper nibble memory, lower nibble I/O
// R12: Select 11 disables ready for ordinary cycles
// R13: Non-pipelined waits equal count plus one
// R14: Host keeps select valid in first T2
// R15: Hold ready high until count elapses
// R16: Sample select after last strobe state
// R17: Host presents select early when pipelined
// R18: Pipelined cycles get one wait fewer
// R19: Halt/shutdown use memory nibble
// R20: Disabled: addressed target makes its ready
// R21: Reset loads all ones into wait registers
// R22: Separate 4-bit refresh count, auto-selected
// R23: Nibble is unsigned count loaded at sample
package wsg_pkg;
	localparam int          ADDR_W      = 9;
	localparam int          CNT_W       = 5;
	// Register indices; byte address is four times index
	localparam logic [7:0]  IDX_WAIT0   = 8'h72;
	localparam logic [7:0]  IDX_WAIT1   = 8'h73;
	localparam logic [7:0]  IDX_WAIT2   = 8'h74;
	localparam logic [7:0]  IDX_REFRESH = 8'h75;
	localparam logic [7:0]  IDX_STATUS  = 8'h76;
	localparam logic [8:0]  ADDR_WAIT0  = {IDX_WAIT0[6:0], 2'b00};
	localparam logic [8:0]  ADDR_WAIT1  = {IDX_WAIT1[6:0], 2'b00};
	localparam logic [8:0]  ADDR_WAIT2  = {IDX_WAIT2[6:0], 2'b00};
	localparam logic [8:0]  ADDR_REFR   = {IDX_REFRESH[6:0], 2'b00};
	localparam logic [8:0]  ADDR_STATUS = {IDX_STATUS[6:0], 2'b00};
	localparam logic [7:0]  WAIT_RESET  = 8'hFF;
	localparam logic [3:0]  REFR_RESET  = 4'hF;
	localparam logic [1:0]  SEL_OFF     = 2'b11;
	localparam logic [4:0]  INTACK_WAIT = 5'h05;
	localparam logic [4:0]  B2B_WAIT    = 5'h07;
	localparam logic [4:0]  PIPE_MIN    = 5'h01;
	// Status register field positions
	localparam int          ST_BUSY     = 0;
	localparam int          ST_PIPE     = 1;
	localparam int          ST_CNT_LSB  = 2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b100
	} bus_state_type;
endpackage

// file: src/wait_cfg_if.sv
`timescale 1ns/100ps
interface wait_cfg_if;
	logic [7:0] wait0;
	logic [7:0] wait1;
	logic [7:0] wait2;
	logic [3:0] refr;
	logic [7:0] status;
	modport bank (output wait0, wait1, wait2, refr, input status);
	modport core (input wait0, wait1, wait2, refr, output status);
endinterface

// file: src/wait_counter.sv
`timescale 1ns/100ps
module wait_counter (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	// Load and expiry
	input  wire logic                        load,
	input  wire logic [wsg_pkg::CNT_W-1:0]   value,
	output logic                             expire,
	output logic      [wsg_pkg::CNT_W-1:0]   count
);
	logic [wsg_pkg::CNT_W-1:0] cnt_q;

	// Down-counter; expires on its last state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= value; // R23
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end

	assign expire = (cnt_q == 5'h01) && !load; // R15
	assign count  = cnt_q;
endmodule

// file: src/wait_reg_bank.sv
`timescale 1ns/100ps
module wait_reg_bank (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// Avalon-MM slave
	input  wire logic [wsg_pkg::ADDR_W-1:0]   address,
	input  wire logic                         read,
	input  wire logic                         write,
	input  wire logic [31:0]                  writedata,
	output logic      [31:0]                  readdata,
	output logic                              waitrequest,
	// Settings to the core
	wait_cfg_if.bank                          cfg
);
	logic [7:0]  w0_q;
	logic [7:0]  w1_q;
	logic [7:0]  w2_q;
	logic [3:0]  rf_q;
	logic [31:0] rd_q;
	logic        wr_q;
	logic        acc;

	// Access completes at the edge with waitrequest low
	assign acc = (read || write) && !wr_q;

	// One wait cycle per access
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= 1'b1;
		end else begin
			wr_q <= !((read || write) && wr_q);
		end
	end

	// Wait registers, all ones after reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			w0_q <= wsg_pkg::WAIT_RESET; // R21
			w1_q <= wsg_pkg::WAIT_RESET; // R21
			w2_q <= wsg_pkg::WAIT_RESET; // R21
			rf_q <= wsg_pkg::REFR_RESET; // R22
		end else if (write && !wr_q) begin
			case (address)
				wsg_pkg::ADDR_WAIT0: w0_q <= writedata[7:0];
				wsg_pkg::ADDR_WAIT1: w1_q <= writedata[7:0];
				wsg_pkg::ADDR_WAIT2: w2_q <= writedata[7:0];
				wsg_pkg::ADDR_REFR:  rf_q <= writedata[3:0]; // R22
				default: ;
			endcase
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= '0;
		end else if ((read || write) && wr_q) begin
			case (address)
				wsg_pkg::ADDR_WAIT0:  rd_q <= {24'h000000, w0_q};
				wsg_pkg::ADDR_WAIT1:  rd_q <= {24'h000000, w1_q};
				wsg_pkg::ADDR_WAIT2:  rd_q <= {24'h000000, w2_q};
				wsg_pkg::ADDR_REFR:   rd_q <= {28'h0000000, rf_q};
				wsg_pkg::ADDR_STATUS: rd_q <= {24'h000000, cfg.status};
				default:              rd_q <= '0;
			endcase
		end
	end

	assign readdata    = rd_q;
	assign waitrequest = wr_q;
	assign cfg.wait0   = w0_q;
	assign cfg.wait1   = w1_q;
	assign cfg.wait2   = w2_q;
	assign cfg.refr    = rf_q;

	a_write_lands: assert property (@(posedge clk) disable iff (!reset_n) // Write reaches wait register 1
		acc && write && address == wsg_pkg::ADDR_WAIT1
		|=> w1_q == $past(writedata[7:0]))
		else $error("wait register 1 write lost");
	a_one_wait: assert property (@(posedge clk) disable iff (!reset_n)
		(read || write) && wr_q |=> !wr_q)
		else $error("access not answered after one wait");
endmodule

// file: src/wait_state_generator.sv
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module wait_state_generator (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// Avalon-MM register port
	input  wire logic [wsg_pkg::ADDR_W-1:0]   avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	output logic      [31:0]                  avs_readdata,
	output logic                              avs_waitrequest,
	// Host bus pins
	input  wire logic                         addr_strobe_n,
	input  wire logic                         ready_in_n,
	input  wire logic [1:0]                   wait_select,
	input  wire logic                         mem_io,
	output logic                              ready_out_n,
	// Cycle type from neighbouring logic
	input  wire logic                         dma_master,
	input  wire logic                         dma_strobe,
	input  wire logic                         own_reg_hit,
	input  wire logic [2:0]                   own_reg_wait,
	input  wire logic                         intc_back_to_back,
	input  wire logic                         int_ack_cycle,
	input  wire logic                         refresh_cycle,
	input  wire logic                         halt_cycle,
	// Master-mode cycle end
	output logic                              dma_cycle_end
);
	wait_cfg_if cfg ();

	logic [4:0]                 sync1_q;
	logic [4:0]                 sync2_q;
	logic                       ads_s;
	logic                       rdy_s;
	logic [1:0]                 sel_s;
	logic                       mio_s;
	logic                       strobe;
	logic                       strobe_seen_q;
	logic                       in_cycle_q;
	logic                       pipe_next_q;
	logic                       pipe_q;
	logic                       sample_ev;
	logic                       off;
	logic [3:0]                 nib;
	logic [4:0]                 base;
	logic [4:0]                 load_cnt;
	logic                       pend_q;
	logic [4:0]                 pend_cnt_q;
	logic                       pend_off_q;
	logic                       start;
	logic                       start_off;
	logic [4:0]                 start_cnt;
	logic                       cnt_load;
	logic                       cnt_exp;
	logic [4:0]                 cnt_val;
	logic                       ready_q;
	logic                       end_q;
	wsg_pkg::bus_state_type     state_q;
	wsg_pkg::bus_state_type     state_d;

	// Register bank on the Avalon port
	wait_reg_bank u_bank (
		.clk         (clk),
		.reset_n     (reset_n),
		.address     (avs_address),
		.read        (avs_read),
		.write       (avs_write),
		.writedata   (avs_writedata),
		.readdata    (avs_readdata),
		.waitrequest (avs_waitrequest),
		.cfg         (cfg)
	);

	// Wait counter
	wait_counter u_cnt (
		.clk     (clk),
		.reset_n (reset_n),
		.load    (cnt_load),
		.value   (start_cnt),
		.expire  (cnt_exp),
		.count   (cnt_val)
	);

	// Two-flop synchronisers for pin inputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 5'h1F;
			sync2_q <= 5'h1F;
		end else begin
			sync1_q <= {addr_strobe_n, ready_in_n, wait_select, mem_io};
			sync2_q <= sync1_q;
		end
	end

	assign ads_s = !sync2_q[4];
	assign rdy_s = !sync2_q[3];
	assign sel_s = sync2_q[2:1];
	assign mio_s = sync2_q[0];

	// Strobe from the CPU or from our own DMA master
	assign strobe = dma_master ? dma_strobe : ads_s; // R2

	// Select sampled the clock after the last strobe state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strobe_seen_q <= 1'b0;
		end else begin
			strobe_seen_q <= strobe;
		end
	end

	assign sample_ev = strobe_seen_q && !strobe; // R16

	// Cycle tracking: strobe before ready means pipelined
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_cycle_q  <= 1'b0;
			pipe_next_q <= 1'b0;
		end else begin
			if (strobe) begin
				in_cycle_q  <= 1'b1;
				pipe_next_q <= in_cycle_q && !rdy_s; // R4
			end else if (rdy_s) begin
				in_cycle_q <= 1'b0; // R4
			end
		end
	end

	// Pipelined flag of the cycle being sampled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pipe_q <= 1'b0;
		end else if (sample_ev) begin
			pipe_q <= pipe_next_q;
		end
	end

	// Nibble choice: memory upper, I/O lower
	always_comb begin
		logic [7:0] r;
		r = cfg.wait0;
		case (sel_s)
			2'b00:   r = cfg.wait0; // R10
			2'b01:   r = cfg.wait1; // R10
			2'b10:   r = cfg.wait2; // R10
			default: r = cfg.wait0;
		endcase
		if (refresh_cycle) begin
			nib = cfg.refr; // R9 R22
		end else if (mio_s || halt_cycle) begin
			nib = r[7:4]; // R11 R19
		end else begin
			nib = r[3:0]; // R11
		end
	end

	// Generator disabled by select 11
	assign off = (sel_s == wsg_pkg::SEL_OFF)
		&& !own_reg_hit && !int_ack_cycle; // R12 R9

	// Wait count for the sampled cycle
	always_comb begin
		if (own_reg_hit) begin
			base = intc_back_to_back ? wsg_pkg::B2B_WAIT
				: {2'b00, own_reg_wait}; // R6
		end else if (int_ack_cycle) begin
			base = wsg_pkg::INTACK_WAIT; // R8
		end else begin
			base = {1'b0, nib} + 5'h01; // R13 R1
		end
		if (!pipe_next_q || int_ack_cycle) begin
			load_cnt = base;
		end else if (own_reg_hit && base <= wsg_pkg::PIPE_MIN) begin
			load_cnt = wsg_pkg::PIPE_MIN; // R7
		end else begin
			load_cnt = base - 5'h01; // R18 R1
		end
	end

	// Sample that arrives while a count runs waits here;
	// a new sample wins over the clear of the one taken now
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_q     <= 1'b0;
			pend_cnt_q <= '0;
			pend_off_q <= 1'b0;
		end else if (sample_ev
			&& (state_q == wsg_pkg::ST_WAIT || pend_q)) begin
			pend_q     <= 1'b1;
			pend_cnt_q <= load_cnt;
			pend_off_q <= off;
		end else if (state_q != wsg_pkg::ST_WAIT) begin
			pend_q <= 1'b0;
		end
	end

	// Start source: pending sample first, else a new one
	always_comb begin
		start     = 1'b0;
		start_off = 1'b0;
		start_cnt = load_cnt;
		if (state_q != wsg_pkg::ST_WAIT && pend_q) begin
			start     = 1'b1;
			start_off = pend_off_q;
			start_cnt = pend_cnt_q;
		end else if (state_q != wsg_pkg::ST_WAIT && sample_ev) begin
			start     = 1'b1;
			start_off = off;
			start_cnt = load_cnt;
		end
	end

	assign cnt_load = start && !start_off && start_cnt != '0; // R23

	// Ready sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			wsg_pkg::ST_IDLE: begin
				if (start && !start_off) begin
					state_d = (start_cnt == '0) ? wsg_pkg::ST_DONE
						: wsg_pkg::ST_WAIT; // R1
				end
			end
			wsg_pkg::ST_WAIT: begin
				if (cnt_exp) begin
					state_d = wsg_pkg::ST_DONE; // R15
				end
			end
			wsg_pkg::ST_DONE: begin
				if (start && !start_off) begin
					state_d = (start_cnt == '0) ? wsg_pkg::ST_DONE
						: wsg_pkg::ST_WAIT;
				end else begin
					state_d = wsg_pkg::ST_IDLE; // R20
				end
			end
			default: state_d = wsg_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= wsg_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Active-low ready out, low for one state at the end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ready_q <= 1'b1;
		end else begin
			ready_q <= (state_d != wsg_pkg::ST_DONE); // R5 R15
		end
	end

	// Master mode: target ready ends our DMA cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			end_q <= 1'b0;
		end else begin
			end_q <= dma_master && in_cycle_q && rdy_s; // R3
		end
	end

	assign ready_out_n   = ready_q;
	assign dma_cycle_end = end_q;
	assign cfg.status    = {1'b0, cnt_val, pipe_q,
		state_q != wsg_pkg::ST_IDLE};

	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Disabled generator, acknowledge and pulse shape
	a_select_off: assert property ( // R12
		sample_ev && state_q == wsg_pkg::ST_IDLE && !pend_q && off
		|=> ready_q [*2])
		else $error("ready driven while disabled");
	a_intack_five: assert property ( // R8
		sample_ev && state_q == wsg_pkg::ST_IDLE && !pend_q
		&& !own_reg_hit && int_ack_cycle
		|=> ready_q [*5] ##1 !ready_q)
		else $error("interrupt acknowledge not five waits");
	a_ready_pulse: assert property ( // R5
		!ready_q && !start |=> ready_q)
		else $error("ready held low too long");

	// Count chosen at the sample edge
	a_nonpipe_plus: assert property ( // R13
		sample_ev && !pipe_next_q && !own_reg_hit && !int_ack_cycle
		&& !refresh_cycle |-> load_cnt == {1'b0, nib} + 5'h01)
		else $error("non-pipelined count not nibble plus one");
	a_pipe_less: assert property ( // R18
		sample_ev && pipe_next_q && !own_reg_hit && !int_ack_cycle
		|-> load_cnt == {1'b0, nib})
		else $error("pipelined count not one fewer");
	a_own_min: assert property ( // R7
		sample_ev && own_reg_hit |-> load_cnt >= wsg_pkg::PIPE_MIN)
		else $error("own register cycle without a wait");
	a_own_count: assert property ( // R6
		sample_ev && own_reg_hit && !intc_back_to_back && !pipe_next_q
		|-> load_cnt == {2'b00, own_reg_wait})
		else $error("own register wait count wrong");
	a_b2b_seven: assert property ( // R6
		sample_ev && own_reg_hit && intc_back_to_back && !pipe_next_q
		|-> load_cnt == wsg_pkg::B2B_WAIT)
		else $error("back-to-back wait count not seven");
	a_refresh_count: assert property ( // R9 R22
		sample_ev && refresh_cycle && !own_reg_hit && !int_ack_cycle
		&& !pipe_next_q |-> load_cnt == {1'b0, cfg.refr} + 5'h01)
		else $error("refresh count not from refresh register");

	// Register halves against the raw settings
	a_io_half: assert property ( // R10 R11
		sample_ev && !pipe_next_q && !own_reg_hit && !int_ack_cycle
		&& !refresh_cycle && !halt_cycle && !mio_s && sel_s == 2'b00
		|-> load_cnt == {1'b0, cfg.wait0[3:0]} + 5'h01)
		else $error("I/O half of register 0 not used");
	a_mem_half: assert property ( // R10 R11
		sample_ev && !pipe_next_q && !own_reg_hit && !int_ack_cycle
		&& !refresh_cycle && !halt_cycle && mio_s && sel_s == 2'b10
		|-> load_cnt == {1'b0, cfg.wait2[7:4]} + 5'h01)
		else $error("memory half of register 2 not used");
	a_halt_memory: assert property ( // R19
		sample_ev && !pipe_next_q && !own_reg_hit && !int_ack_cycle
		&& !refresh_cycle && halt_cycle && sel_s == 2'b01
		|-> load_cnt == {1'b0, cfg.wait1[7:4]} + 5'h01)
		else $error("halt cycle not using memory half");

	// Counting and master mode
	a_wait_high: assert property ( // R15
		state_q == wsg_pkg::ST_WAIT && !cnt_exp |=> ready_q)
		else $error("ready dropped before count ran out");
	a_master_end: assert property ( // R3
		dma_master && in_cycle_q && rdy_s && !strobe
		|=> end_q ##1 !in_cycle_q)
		else $error("master cycle end missed");
	a_master_quiet: assert property ( // R3
		!dma_master |=> !end_q)
		else $error("cycle end flagged in slave mode");

	c_nonpipe: cover property (sample_ev && !pipe_next_q && !off);
	c_pipe: cover property (sample_ev && pipe_next_q && !off);
	c_pending: cover property (state_q == wsg_pkg::ST_DONE && pend_q);
	c_intack: cover property (sample_ev && int_ack_cycle);
	c_master_end: cover property (end_q);
endmodule

// file: bench/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model #(
	parameter int TARGET_WAIT = 4,
	parameter int HOLD        = 5
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Requests from the bench
	input  wire logic       start,
	input  wire logic [1:0] sel,
	input  wire logic       mio,
	// Bus pins
	input  wire logic       ready_out_n,
	output logic            addr_strobe_n,
	output logic [1:0]      wait_select,
	output logic            mem_io,
	output logic            ready_in_n
);
	int hold_q;
	int tgt_q;
	// One strobe state; select shown with it, dropped once hold runs out
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_strobe_n <= 1'b1;
			wait_select   <= 2'b01;
			mem_io        <= 1'b0;
			hold_q        <= 0;
		end else if (start) begin
			addr_strobe_n <= 1'b0;
			wait_select   <= sel;
			mem_io        <= mio;
			hold_q        <= HOLD;
		end else begin
			addr_strobe_n <= 1'b1;
			if (hold_q == 1) begin
				wait_select <= ~wait_select;
				mem_io      <= ~mem_io;
			end
			if (hold_q > 0)
				hold_q <= hold_q - 1;
		end
	end
	// Target times its own ready when the generator is off
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			tgt_q <= 0;
		else if (start)
			tgt_q <= (sel == 2'b11) ? TARGET_WAIT : 0;
		else if (tgt_q > 0)
			tgt_q <= tgt_q - 1;
	end
	// Simplest wiring: generator ready fed back, target may end early
	assign ready_in_n = ready_out_n & (tgt_q != 1);
endmodule

// file: bench/wait_state_generator_tb.sv
`timescale 1ns/100ps
module wait_state_generator_tb;
	localparam int LAT = 6;
	typedef struct {
		logic       mio;
		logic [1:0] sel;
		int         kind;
		int         waits;
	} row_type;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [8:0]  avs_address = 9'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        addr_strobe_n;
	logic        ready_in_n;
	logic [1:0]  wait_select;
	logic        mem_io;
	logic        ready_out_n;
	logic        dma_master = 1'b0;
	logic        dma_strobe = 1'b0;
	logic        own_reg_hit = 1'b0;
	logic [2:0]  own_reg_wait = 3'h3;
	logic        intc_back_to_back = 1'b0;
	logic        int_ack_cycle = 1'b0;
	logic        refresh_cycle = 1'b0;
	logic        halt_cycle = 1'b0;
	logic        dma_cycle_end;
	logic        start = 1'b0;
	logic [1:0]  sel = 2'b00;
	logic        mio = 1'b0;
	int          failures = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [31:0] rd;
	int          n;
	int          lows;
	int          ends;
	// Ordinary cases: kind 0 plain, 1 own reg, 2 back-to-back,
	// 3 interrupt acknowledge, 4 refresh, 5 halt; -1 means no pulse
	row_type rows [13] = '{
		'{1'b1, 2'b00, 0, 4},
		'{1'b0, 2'b00, 0, 1},
		'{1'b1, 2'b01, 0, 7},
		'{1'b0, 2'b01, 0, 11},
		'{1'b1, 2'b10, 0, 16},
		'{1'b0, 2'b10, 0, 1},
		'{1'b1, 2'b11, 0, -1},
		'{1'b0, 2'b00, 1, 3},
		'{1'b0, 2'b00, 2, 7},
		'{1'b0, 2'b11, 3, 5},
		'{1'b0, 2'b00, 4, 3},
		'{1'b0, 2'b11, 4, -1},
		'{1'b0, 2'b01, 5, 7}
	};
	wait_state_generator DUT (
		.clk               (clk),
		.reset_n           (reset_n),
		.avs_address       (avs_address),
		.avs_read          (avs_read),
		.avs_write         (avs_write),
		.avs_writedata     (avs_writedata),
		.avs_readdata      (avs_readdata),
		.avs_waitrequest   (avs_waitrequest),
		.addr_strobe_n     (addr_strobe_n),
		.ready_in_n        (ready_in_n),
		.wait_select       (wait_select),
		.mem_io            (mem_io),
		.ready_out_n       (ready_out_n),
		.dma_master        (dma_master),
		.dma_strobe        (dma_strobe),
		.own_reg_hit       (own_reg_hit),
		.own_reg_wait      (own_reg_wait),
		.intc_back_to_back (intc_back_to_back),
		.int_ack_cycle     (int_ack_cycle),
		.refresh_cycle     (refresh_cycle),
		.halt_cycle        (halt_cycle),
		.dma_cycle_end     (dma_cycle_end)
	);
	host_bus_model partner (
		.clk           (clk),
		.reset_n       (reset_n),
		.start         (start),
		.sel           (sel),
		.mio           (mio),
		.ready_out_n   (ready_out_n),
		.addr_strobe_n (addr_strobe_n),
		.wait_select   (wait_select),
		.mem_io        (mem_io),
		.ready_in_n    (ready_in_n)
	);
	// Clock
	always #50 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_waits(input int got, input int exp);
		check_reg(32'(got), 32'(exp));
	endtask
	task automatic check_flag(input logic got, input logic exp);
		check_reg({31'h0, got}, {31'h0, exp});
	endtask
	// Register access; held until waitrequest is seen low
	task automatic bus_access(input logic wr, input logic [8:0] a,
			input logic [31:0] wd, output logic [31:0] data);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		data = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic set_kind(input int kind);
		own_reg_hit <= (kind == 1) || (kind == 2);
		intc_back_to_back <= (kind == 2);
		int_ack_cycle <= (kind == 3);
		refresh_cycle <= (kind == 4);
		halt_cycle <= (kind == 5);
	endtask
	task automatic pulse_start();
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask
	// Counts ready pulses and master-mode ends over a span
	task automatic watch(input int span, output int l, output int e);
		l = 0;
		e = 0;
		repeat (span) begin
			@(posedge clk);
			if (ready_out_n === 1'b0)
				l++;
			if (dma_cycle_end === 1'b1)
				e++;
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		// Reset values, then programming and read-back
		bus_access(1'b0, wsg_pkg::ADDR_WAIT0, 32'h0, rd);
		check_reg(rd, 32'h000000FF);
		bus_access(1'b0, wsg_pkg::ADDR_REFR, 32'h0, rd);
		check_reg(rd, 32'h0000000F);
		bus_access(1'b1, wsg_pkg::ADDR_WAIT0, 32'h00000030, rd);
		bus_access(1'b1, wsg_pkg::ADDR_WAIT1, 32'h0000006A, rd);
		bus_access(1'b1, wsg_pkg::ADDR_WAIT2, 32'h000000F0, rd);
		bus_access(1'b1, wsg_pkg::ADDR_REFR, 32'hFFFFFF32, rd);
		bus_access(1'b1, 9'h000, 32'h000000AA, rd);
		bus_access(1'b0, 9'h000, 32'h0, rd);
		check_reg(rd, 32'h00000000);
		bus_access(1'b0, wsg_pkg::ADDR_STATUS, 32'h0, rd);
		check_reg(rd, 32'h00000000);
		bus_access(1'b0, wsg_pkg::ADDR_WAIT1, 32'h0, rd);
		check_reg(rd, 32'h0000006A);
		bus_access(1'b0, wsg_pkg::ADDR_REFR, 32'h0, rd);
		check_reg(rd, 32'h00000002);
		// Table of bus cycles: edges from request to ready pulse
		foreach (rows[i]) begin
			@(posedge clk);
			set_kind(rows[i].kind);
			sel <= rows[i].sel;
			mio <= rows[i].mio;
			pulse_start();
			n = -1;
			for (int k = 2; k < 60 && n < 0; k++) begin
				@(posedge clk);
				if (ready_out_n === 1'b0)
					n = k;
			end
			check_waits(n, rows[i].waits < 0 ? -1 : rows[i].waits + LAT);
			if (n > 0) begin
				@(posedge clk);
				check_flag(ready_out_n, 1'b1);
			end
			repeat (8) @(posedge clk);
		end
		// Pipelined: second strobe before the first ready
		set_kind(0);
		sel <= 2'b00;
		mio <= 1'b1;
		pulse_start();
		repeat (2) @(posedge clk);
		pulse_start();
		watch(60, lows, ends);
		check_waits(lows, 2);
		// Master mode: select on the pins first, then our own strobe
		dma_master <= 1'b1;
		pulse_start();
		@(posedge clk);
		dma_strobe <= 1'b1;
		@(posedge clk);
		dma_strobe <= 1'b0;
		watch(60, lows, ends);
		check_waits(lows, 1);
		check_waits(ends, 1);
		dma_master <= 1'b0;
		// Reset in mid-count drops the pending ready
		sel <= 2'b10;
		pulse_start();
		repeat (5) @(posedge clk);
		reset_n <= 1'b0;
		watch(30, lows, ends);
		check_waits(lows, 0);
		check_flag(avs_waitrequest, 1'b1);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		bus_access(1'b0, wsg_pkg::ADDR_WAIT2, 32'h0, rd);
		check_reg(rd, 32'h000000FF);
		end_of_test();
	end
endmodule
